/* File: src/cis_cfg.svh */
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
`define CIS_OFS_INSTR    8'h00
`define CIS_OFS_ADDR     8'h04
`define CIS_OFS_DATA     8'h08
`define CIS_OFS_CTRL     8'h0C
`define CIS_OFS_FLAGS    8'h10
`define CIS_OFS_STATUS   8'h14
`define CIS_OFS_DUMMY    8'h18
`define CIS_FLAGS_RST    8'h00
`define CIS_FLAG_N       7
`define CIS_FLAG_V       6
`define CIS_FLAG_D       3
`define CIS_FLAG_Z       1
`define CIS_FLAG_C       0
`define CIS_CTRL_GO      0
`define CIS_CTRL_RESET   1
`define CIS_CTRL_IRQ     2
`define CIS_INSTR_IDX    16
`define CIS_INSTR_TAKEN  17
`define CIS_SVC_CYCLES   4'h7
`define CIS_RMW_SAME_PG  4'h6
`define CIS_PUSH_WRITES  2'h3
`define CIS_NOP5C_CYCLES 4'h8
`define CIS_OP_SWBREAK   8'h00
`define CIS_OP_INDJUMP   8'h6C
`define CIS_OP_BITIMM    8'h89
`endif

/* File: src/cis_pkg.sv */
package cis_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_SVC  = 2'b10,
    S_RST  = 2'b11
  } cis_state_type;

  typedef struct packed {
    cis_state_type state;
    logic [3:0]    count;
    logic          awReady;
    logic          wReady;
    logic          awHeld;
    logic          wHeld;
    logic          bValid;
    logic [1:0]    bResp;
    logic          arReady;
    logic          rValid;
    logic [1:0]    rResp;
    logic [7:0]    awAddr;
    logic [31:0]   wData;
    logic [3:0]    wStrb;
    logic [31:0]   rData;
    logic [31:0]   instr;
    logic [31:0]   addr;
    logic [31:0]   data;
    logic [7:0]    flags;
    logic [7:0]    pendFlags;
    logic [7:0]    atGoFlags;
    logic          irqPend;
    logic          svcDone;
    logic          brkThenSvc;
    logic          lastUndef;
    logic          dummyUsed;
    logic [3:0]    lastCycles;
    logic [1:0]    lastBytes;
    logic [1:0]    rdCnt;
    logic [1:0]    wrCnt;
    logic [15:0]   dummyAddr;
  } cis_regs_type;
endpackage

/* File: src/cis_sequencer.sv */
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cis_cfg.svh"
module cis_sequencer (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  cis_pkg::cis_regs_type st_ff;
  cis_pkg::cis_regs_type nxt_st;

  // {undefined, bytes, cycles}
  function automatic logic [6:0] undefInfo(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    if (lo == 4'h3 || lo == 4'h7 || lo == 4'hB || lo == 4'hF) begin
      undefInfo = {1'b1, 2'h1, 4'h1};
    end else if (lo == 4'h2 && !op[4] && op != 8'hA2) begin
      undefInfo = {1'b1, 2'h2, 4'h2};
    end else if (op == 8'h44) begin
      undefInfo = {1'b1, 2'h2, 4'h3};
    end else if (op == 8'h54 || op == 8'hD4 || op == 8'hF4) begin
      undefInfo = {1'b1, 2'h2, 4'h4};
    end else if (op == 8'h5C) begin
      undefInfo = {1'b1, 2'h3, `CIS_NOP5C_CYCLES};
    end else if (op == 8'hDC || op == 8'hFC) begin
      undefInfo = {1'b1, 2'h3, 4'h4};
    end else begin
      undefInfo = 7'h00;
    end
  endfunction

  function automatic logic isRmwMem(input logic [7:0] op);
    logic okGroup;
    okGroup = op[7:5] != 3'h4 && op[7:5] != 3'h5;
    isRmwMem = (okGroup && (op[3:0] == 4'h6 || op[3:0] == 4'hE)) || isTestBits(op);
  endfunction

  function automatic logic isTestBits(input logic [7:0] op);
    isTestBits = op == 8'h04 || op == 8'h0C || op == 8'h14 || op == 8'h1C;
  endfunction

  function automatic logic isArith(input logic [7:0] op);
    logic [3:0] lo;
    lo = op[3:0];
    isArith = (op[6:5] == 2'h3) && (lo == 4'h1 || lo == 4'h5 || lo == 4'h9 || lo == 4'hD ||
              (lo == 4'h2 && op[4]));
  endfunction

  // {carry, overflow, result}
  function automatic logic [9:0] addSub(input logic [7:0] a, input logic [7:0] m,
                                        input logic c, input logic dec, input logic sub);
    logic [7:0] mm;
    logic [8:0] bin;
    logic [4:0] lo;
    logic [4:0] hi;
    logic       v;
    mm  = sub ? ~m : m;
    bin = {1'b0, a} + {1'b0, mm} + {8'h00, c};
    v   = (a[7] == mm[7]) && (bin[7] != a[7]);
    lo  = 5'h00;
    hi  = 5'h00;
    if (!dec) begin
      addSub = {bin[8], v, bin[7:0]};
    end else if (!sub) begin
      lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
      if (lo > 5'h09) lo = lo + 5'h06;
      hi = {1'b0, a[7:4]} + {1'b0, m[7:4]} + {4'h0, lo[4]};
      if (hi > 5'h09) hi = hi + 5'h06;
      addSub = {hi[4], v, hi[3:0], lo[3:0]};
    end else begin
      lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, !c};
      if (lo[4]) lo = lo - 5'h06;
      hi = {1'b0, a[7:4]} - {1'b0, m[7:4]} - {4'h0, lo[4]};
      if (hi[4]) hi = hi - 5'h06;
      addSub = {!hi[4], v, hi[3:0], lo[3:0]};
    end
  endfunction

  logic [7:0]  op;
  logic [15:0] baseAddr;
  logic [7:0]  idx;
  logic [7:0]  regA;
  logic [7:0]  regM;
  logic [15:0] effAddr;
  logic [15:0] brTarget;
  logic        crossPage;
  logic        brFar;
  logic [6:0]  undef;
  logic        isBranch;
  logic        exempt;
  logic        rmwAbsX;
  logic        addCross;
  logic [3:0]  addBranch;
  logic        addDec;
  logic        addPtr;
  logic [3:0]  totalCycles;
  logic [9:0]  arith;
  logic [7:0]  andAm;
  logic [7:0]  opFlags;
  logic        doWrite;
  logic        goAccept;
  logic        rstAccept;
  logic        irqReq;

  assign op        = st_ff.instr[7:0];
  assign baseAddr  = st_ff.addr[15:0];
  assign idx       = st_ff.addr[23:16];
  assign regA      = st_ff.data[7:0];
  assign regM      = st_ff.data[15:8];
  assign effAddr   = baseAddr + {8'h00, idx};
  assign brTarget  = baseAddr + {{8{idx[7]}}, idx};
  assign crossPage = effAddr[15:8] != baseAddr[15:8];
  assign brFar     = brTarget[15:8] != baseAddr[15:8];
  assign undef     = undefInfo(op);
  assign isBranch  = op == 8'h80 || op[4:0] == 5'h10;
  assign exempt    = op == 8'h9D || op == 8'h99 || op == 8'h91 || op == 8'h9E;
  assign rmwAbsX   = isRmwMem(op) && op[4] && op[3:0] == 4'hE;
  assign addCross  = st_ff.instr[`CIS_INSTR_IDX] && crossPage && !exempt;
  assign addBranch = (isBranch && st_ff.instr[`CIS_INSTR_TAKEN]) ? (brFar ? 4'h2 : 4'h1) : 4'h0;
  assign addDec    = isArith(op) && st_ff.flags[`CIS_FLAG_D];
  assign addPtr    = op == `CIS_OP_INDJUMP && baseAddr[7:0] == 8'hFF;
  assign arith     = addSub(regA, regM, st_ff.flags[`CIS_FLAG_C], st_ff.flags[`CIS_FLAG_D], op[7]);
  assign andAm     = regA & regM;

  always_comb begin
    totalCycles = st_ff.instr[11:8] + {3'h0, addCross} + addBranch + {3'h0, addDec} + {3'h0, addPtr};
    if (undef[6]) begin
      totalCycles = undef[3:0];
    end else if (rmwAbsX) begin
      totalCycles = `CIS_RMW_SAME_PG + {3'h0, crossPage};
    end
  end

  always_comb begin
    opFlags = st_ff.flags;
    if (undef[6]) begin
      opFlags = st_ff.flags;
    end else if (op == `CIS_OP_BITIMM) begin
      opFlags[`CIS_FLAG_Z] = andAm == 8'h00;
    end else if (isTestBits(op) || op == 8'h24 || op == 8'h2C || op == 8'h34 || op == 8'h3C) begin
      opFlags[`CIS_FLAG_Z] = andAm == 8'h00;
      if (!isTestBits(op)) begin
        opFlags[`CIS_FLAG_N] = regM[7];
        opFlags[`CIS_FLAG_V] = regM[6];
      end
    end else if (isArith(op)) begin
      opFlags[`CIS_FLAG_N] = arith[7];
      opFlags[`CIS_FLAG_Z] = arith[7:0] == 8'h00;
      opFlags[`CIS_FLAG_V] = arith[8];
      opFlags[`CIS_FLAG_C] = arith[9];
    end
  end

  assign doWrite   = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
  assign goAccept  = doWrite && st_ff.awAddr == `CIS_OFS_CTRL && st_ff.wStrb[0] &&
                     st_ff.wData[`CIS_CTRL_GO] && !st_ff.wData[`CIS_CTRL_RESET] &&
                     st_ff.state == cis_pkg::S_IDLE && !st_ff.irqPend;
  assign rstAccept = doWrite && st_ff.awAddr == `CIS_OFS_CTRL && st_ff.wStrb[0] &&
                     st_ff.wData[`CIS_CTRL_RESET] && st_ff.state == cis_pkg::S_IDLE;
  assign irqReq    = doWrite && st_ff.awAddr == `CIS_OFS_CTRL && st_ff.wStrb[0] &&
                     st_ff.wData[`CIS_CTRL_IRQ];

  always_comb begin
    nxt_st = st_ff;
    // register bus
    if (awvalid && st_ff.awReady) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = awaddr;
    end
    if (wvalid && st_ff.wReady) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = wdata;
      nxt_st.wStrb = wstrb;
    end
    if (st_ff.bValid && bready) begin
      nxt_st.bValid = 1'b0;
    end
    if (doWrite) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = 2'h0;
      for (int i = 0; i < 4; i++) begin
        if (st_ff.wStrb[i]) begin
          case (st_ff.awAddr)
            `CIS_OFS_INSTR: nxt_st.instr[i*8 +: 8] = st_ff.wData[i*8 +: 8];
            `CIS_OFS_ADDR:  nxt_st.addr[i*8 +: 8]  = st_ff.wData[i*8 +: 8];
            `CIS_OFS_DATA:  nxt_st.data[i*8 +: 8]  = st_ff.wData[i*8 +: 8];
            default: ;
          endcase
        end
      end
      if (st_ff.awAddr == `CIS_OFS_FLAGS && st_ff.wStrb[0] && st_ff.state == cis_pkg::S_IDLE) begin
        nxt_st.flags = st_ff.wData[7:0];
      end
      if (!(st_ff.awAddr inside {`CIS_OFS_INSTR, `CIS_OFS_ADDR, `CIS_OFS_DATA, `CIS_OFS_CTRL,
                                 `CIS_OFS_FLAGS, `CIS_OFS_STATUS, `CIS_OFS_DUMMY})) begin
        nxt_st.bResp = 2'h2;
      end
    end
    nxt_st.awReady = !nxt_st.awHeld && !nxt_st.bValid;
    nxt_st.wReady  = !nxt_st.wHeld && !nxt_st.bValid;
    if (st_ff.rValid && rready) begin
      nxt_st.rValid = 1'b0;
    end
    if (arvalid && st_ff.arReady) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp  = 2'h0;
      case (araddr)
        `CIS_OFS_INSTR:  nxt_st.rData = st_ff.instr;
        `CIS_OFS_ADDR:   nxt_st.rData = st_ff.addr;
        `CIS_OFS_DATA:   nxt_st.rData = st_ff.data;
        `CIS_OFS_CTRL:   nxt_st.rData = {29'h0, st_ff.irqPend, 1'b0, st_ff.state != cis_pkg::S_IDLE};
        `CIS_OFS_FLAGS:  nxt_st.rData = {24'h0, st_ff.flags};
        `CIS_OFS_STATUS: nxt_st.rData = {12'h0, st_ff.brkThenSvc, st_ff.svcDone, st_ff.dummyUsed,
                                         st_ff.lastUndef, 2'h0, st_ff.wrCnt, st_ff.rdCnt,
                                         st_ff.lastBytes, st_ff.lastCycles, st_ff.count};
        `CIS_OFS_DUMMY:  nxt_st.rData = {16'h0, st_ff.dummyAddr};
        default: begin
          nxt_st.rData = 32'h0000_0000;
          nxt_st.rResp = 2'h2;
        end
      endcase
    end
    nxt_st.arReady = !nxt_st.rValid;
    // sequencing engine
    case (st_ff.state)
      cis_pkg::S_IDLE: begin
        if (rstAccept) begin
          nxt_st.state     = cis_pkg::S_RST;
          nxt_st.count     = `CIS_SVC_CYCLES;
          nxt_st.rdCnt     = 2'h0;
          nxt_st.wrCnt     = `CIS_PUSH_WRITES;
          nxt_st.flags[`CIS_FLAG_D] = 1'b0;
        end else if (st_ff.irqPend) begin
          nxt_st.state     = cis_pkg::S_SVC;
          nxt_st.count     = `CIS_SVC_CYCLES;
          nxt_st.irqPend   = 1'b0;
          nxt_st.svcDone   = 1'b0;
          nxt_st.brkThenSvc = 1'b0;
          nxt_st.rdCnt     = 2'h0;
          nxt_st.wrCnt     = `CIS_PUSH_WRITES;
          nxt_st.flags[`CIS_FLAG_D] = 1'b0;
        end else if (goAccept) begin
          nxt_st.state      = cis_pkg::S_EXEC;
          nxt_st.count      = totalCycles;
          nxt_st.lastCycles = totalCycles;
          nxt_st.lastBytes  = undef[6] ? undef[5:4] : st_ff.instr[13:12];
          nxt_st.lastUndef  = undef[6];
          nxt_st.pendFlags  = opFlags;
          nxt_st.atGoFlags  = st_ff.flags;
          nxt_st.svcDone    = 1'b0;
          nxt_st.brkThenSvc = 1'b0;
          nxt_st.rdCnt      = isRmwMem(op) && !undef[6] ? 2'h2 : 2'h0;
          nxt_st.wrCnt      = isRmwMem(op) && !undef[6] ? 2'h1 : 2'h0;
          nxt_st.dummyUsed  = !undef[6] && (rmwAbsX ? crossPage : addCross);
          nxt_st.dummyAddr  = st_ff.data[31:16] + {14'h0, st_ff.instr[13:12]} - 16'h0001;
        end
      end
      cis_pkg::S_EXEC: begin
        nxt_st.count = st_ff.count - 4'h1;
        if (st_ff.count == 4'h1) begin
          nxt_st.flags = st_ff.pendFlags;
          if (st_ff.irqPend) begin
            // the break completes first, then the interrupt is taken
            nxt_st.state      = cis_pkg::S_SVC;
            nxt_st.count      = `CIS_SVC_CYCLES;
            nxt_st.irqPend    = 1'b0;
            nxt_st.brkThenSvc = op == `CIS_OP_SWBREAK;
            nxt_st.rdCnt      = 2'h0;
            nxt_st.wrCnt      = `CIS_PUSH_WRITES;
            nxt_st.flags[`CIS_FLAG_D] = 1'b0;
          end else begin
            nxt_st.state = cis_pkg::S_IDLE;
          end
        end
      end
      cis_pkg::S_SVC, cis_pkg::S_RST: begin
        nxt_st.count = st_ff.count - 4'h1;
        if (st_ff.count == 4'h1) begin
          nxt_st.state   = cis_pkg::S_IDLE;
          nxt_st.svcDone = st_ff.state == cis_pkg::S_SVC;
        end
      end
      default: nxt_st.state = cis_pkg::S_IDLE;
    endcase
    // a request arriving as the pending bit is consumed is kept
    if (irqReq) begin
      nxt_st.irqPend = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff         <= '0;
      st_ff.flags   <= `CIS_FLAGS_RST;
      st_ff.awReady <= 1'b1;
      st_ff.wReady  <= 1'b1;
      st_ff.arReady <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awReady;
  assign wready  = st_ff.wReady;
  assign bvalid  = st_ff.bValid;
  assign bresp   = st_ff.bResp;
  assign arready = st_ff.arReady;
  assign rvalid  = st_ff.rValid;
  assign rdata   = st_ff.rData;
  assign rresp   = st_ff.rResp;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence svcEntry;
    st_ff.state == cis_pkg::S_SVC && st_ff.count == `CIS_SVC_CYCLES;
  endsequence
  sequence svcFinish;
    st_ff.state == cis_pkg::S_SVC ##1 st_ff.state == cis_pkg::S_IDLE && st_ff.svcDone;
  endsequence

  store_cross_fixed_a: assert property (
    goAccept && exempt && crossPage && st_ff.instr[`CIS_INSTR_IDX] |=> st_ff.lastCycles == $past(st_ff.instr[11:8]))
    else $error("store op cycle count changed by page cross");
  branch_far_a: assert property (
    goAccept && isBranch && !undef[6] && st_ff.instr[`CIS_INSTR_TAKEN] && brFar
    |=> st_ff.lastCycles == $past(st_ff.instr[11:8]) + 4'h2)
    else $error("far taken branch not two extra cycles");
  bit_imm_nv_a: assert property (
    goAccept && op == `CIS_OP_BITIMM |=> st_ff.pendFlags[7:6] == $past(st_ff.flags[7:6]))
    else $error("immediate bit test altered N or V");
  nop_long_a: assert property (
    goAccept && op == 8'h5C |=> st_ff.lastCycles == `CIS_NOP5C_CYCLES && st_ff.lastBytes == 2'h3
    ##7 st_ff.state == cis_pkg::S_EXEC ##1 st_ff.state != cis_pkg::S_EXEC)
    else $error("5C no-operation not 3 bytes 8 cycles");
  ptr_wrap_a: assert property (
    goAccept && op == `CIS_OP_INDJUMP && baseAddr[7:0] == 8'hFF
    |=> st_ff.lastCycles == $past(st_ff.instr[11:8]) + 4'h1)
    else $error("pointer at page end missing extra cycle");
  rmw_access_a: assert property (
    goAccept && isRmwMem(op) && !undef[6] |=> st_ff.rdCnt == 2'h2 && st_ff.wrCnt == 2'h1)
    else $error("read-modify-write not two reads one write");
  svc_clear_d_a: assert property (
    svcEntry |-> !st_ff.flags[`CIS_FLAG_D] ##6 svcFinish)
    else $error("interrupt service left D set or did not run seven cycles");
  break_then_svc_a: assert property (
    st_ff.state == cis_pkg::S_EXEC && st_ff.count == 4'h1 && st_ff.irqPend && op == `CIS_OP_SWBREAK
    |=> (svcEntry and (st_ff.brkThenSvc && !st_ff.flags[`CIS_FLAG_D])) ##6 svcFinish)
    else $error("interrupt after break not serviced in order");
  reset_push_a: assert property (
    rstAccept |=> st_ff.state == cis_pkg::S_RST && st_ff.wrCnt == `CIS_PUSH_WRITES &&
    !st_ff.flags[`CIS_FLAG_D] ##7 st_ff.state == cis_pkg::S_IDLE)
    else $error("reset sequence did not push three bytes");
  rmw_same_page_a: assert property (
    goAccept && rmwAbsX && !crossPage |=> st_ff.lastCycles == `CIS_RMW_SAME_PG)
    else $error("same-page indexed read-modify-write not six cycles");
  nop_flags_a: assert property (
    st_ff.state == cis_pkg::S_EXEC && st_ff.count == 4'h1 && st_ff.lastUndef && !st_ff.irqPend
    |=> st_ff.flags == st_ff.atGoFlags)
    else $error("undefined opcode changed flags");
endmodule
`default_nettype wire

/* File: test/cis_axi_host.sv */
`timescale 1ns/1ns
`default_nettype none
module cis_axi_host (
  input  wire logic        clock,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (++n > 50) testbench.hang();
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (++n > 50) testbench.hang();
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cis_cfg.svh"
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          failures = 0;
  int          totalChecks = 0;
  int          seed = 71;
  // op n cyc flagsIn A M flagsOut bytes {rmw,idx} base index
  localparam logic [79:0] OP_TAB [9] = '{
    80'h69_2_3_08_45_55_4B_2_0_2000_00, 80'h69_2_2_00_45_55_C0_2_0_2000_00,
    80'h89_2_2_C0_0F_F0_C2_2_0_2000_00, 80'h0C_6_6_00_01_10_02_3_2_2000_00,
    80'h1C_6_6_02_11_10_00_3_2_2000_00, 80'h1E_7_6_00_00_01_00_3_3_1200_10,
    80'h1E_7_7_00_00_01_00_3_3_12F0_20, 80'h6C_5_6_00_00_00_00_3_0_10FF_00,
    80'h6C_5_5_00_00_00_00_3_0_1000_00};
  // op bytes cycles
  localparam logic [15:0] NOP_TAB [13] = '{16'h0222, 16'hE222, 16'h0311, 16'hB711, 16'hFB11,
    16'h2F11, 16'h4423, 16'h5424, 16'hD424, 16'hF424, 16'h5C38, 16'hDC34, 16'hFC34};

  always #20 clock = ~clock;

  cis_sequencer u_dut (.clock(clock), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  cis_axi_host u_host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic summarize;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic hang;
    failures++;
    summarize();
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr(a, d, r);
  endtask
  task automatic see(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] v;
    logic [1:0]  r;
    u_host.rd(a, v, r);
    `CHK(nm, e, v & m)
  endtask
  task automatic waitIdle;
    logic [31:0] v;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      u_host.rd(`CIS_OFS_CTRL, v, r);
      if (++n > 60) hang();
    end while (v[0] !== 1'b0 || v[2] !== 1'b0);
  endtask
  task automatic runOp(input logic [31:0] ins, adr, dat);
    put(`CIS_OFS_INSTR, ins);
    put(`CIS_OFS_ADDR, adr);
    put(`CIS_OFS_DATA, dat);
    put(`CIS_OFS_CTRL, 32'h1);
    waitIdle();
  endtask
  function automatic logic [31:0] mk(input logic [7:0] op, input logic [3:0] n, input logic [1:0] b,
                                     input logic x, t);
    return {14'h0, t, x, 2'b0, b, n, op};
  endfunction
  function automatic logic [3:0] idxCycles(input logic [7:0] op, input logic [15:0] b, input logic [7:0] x);
    logic [15:0] e;
    e = b + {8'h0, x};
    return ((op == 8'h9D) ? 4'h5 : 4'h4) + {3'h0, e[15:8] != b[15:8] && op != 8'h9D};
  endfunction
  function automatic logic [3:0] brCycles(input logic t, input logic [15:0] nxt, tgt);
    return !t ? 4'h2 : (nxt[15:8] == tgt[15:8]) ? 4'h3 : 4'h4;
  endfunction
  task automatic idxCase(input logic [7:0] op, input logic [15:0] b, input logic [7:0] x, input logic [15:0] pc);
    logic [3:0] c;
    c = idxCycles(op, b, x);
    runOp(mk(op, (op == 8'h9D) ? 4'h5 : 4'h4, 2'h3, 1'b1, 1'b0), {8'h0, x, b}, {pc, 16'h0});
    see("idx cycles", `CIS_OFS_STATUS, 32'hF0, {24'h0, c, 4'h0});
    if (op == 8'hBD) see("dummy used", `CIS_OFS_STATUS, 32'h20000, {14'h0, c == 4'h5, 17'h0});
    if (op == 8'hBD && c == 4'h5) see("dummy addr", `CIS_OFS_DUMMY, 32'hFFFF, {16'h0, pc + 16'h2});
  endtask

  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [79:0] row;
    logic [7:0]  f;
    logic [15:0] tgt;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    see("flags rst", `CIS_OFS_FLAGS, 32'hFF, {24'h0, `CIS_FLAGS_RST});
    see("status rst", `CIS_OFS_STATUS, 32'hFFFFFFFF, 32'h0);
    u_host.rd(8'h1C, v, r);
    `CHK("unmapped rresp", 2'b10, r)
    u_host.wr(8'h1C, 32'h0, r);
    `CHK("unmapped bresp", 2'b10, r)
    $display("test reset done");
    foreach (NOP_TAB[i]) begin
      f = 8'($random(seed));
      put(`CIS_OFS_FLAGS, {24'h0, f});
      runOp(mk(NOP_TAB[i][15:8], 4'($random(seed)), 2'h0, 1'b0, 1'b0), $random(seed), {16'h0400, 16'($random(seed))});
      see("nop shape", `CIS_OFS_STATUS, 32'h103F0, {15'h0, 1'b1, 6'h0, NOP_TAB[i][5:4], NOP_TAB[i][3:0], 4'h0});
      see("nop flags", `CIS_OFS_FLAGS, 32'hFF, {24'h0, f});
    end
    $display("test undefined done");
    idxCase(8'hBD, 16'h12F0, 8'h20, 16'h0810);
    idxCase(8'h9D, 16'h12F0, 8'h20, 16'h0810);
    repeat (8) idxCase(($random(seed) & 1) ? 8'h9D : 8'hBD, 16'($random(seed)), 8'($random(seed)), 16'($random(seed)));
    $display("test indexed done");
    for (int i = 0; i < 3; i++) begin
      // address after the branch in the low half, signed offset above it
      tgt = (i == 1) ? 16'h2FF0 : 16'h3040;
      runOp(mk(8'hF0, 4'h2, 2'h2, 1'b0, i != 2), {8'h0, 8'(tgt - 16'h3012), 16'h3012}, 32'h3010_0000);
      see("branch cycles", `CIS_OFS_STATUS, 32'hF0, {24'h0, brCycles(i != 2, 16'h3012, tgt), 4'h0});
    end
    $display("test branch done");
    foreach (OP_TAB[i]) begin
      row = OP_TAB[i];
      put(`CIS_OFS_FLAGS, {24'h0, row[63:56]});
      runOp(mk(row[79:72], row[71:68], row[29:28], row[24], 1'b0), {8'h0, row[7:0], row[23:8]},
            {16'h0300, row[47:40], row[55:48]});
      see("op flags", `CIS_OFS_FLAGS, 32'hFF, {24'h0, row[39:32]});
      see("op cycles", `CIS_OFS_STATUS, 32'hF0, {24'h0, row[67:64], 4'h0});
      if (row[25]) see("rmw access", `CIS_OFS_STATUS, 32'h3C00, 32'h1800);
    end
    $display("test opcodes done");
    put(`CIS_OFS_FLAGS, 32'h08);
    put(`CIS_OFS_CTRL, 32'h2);
    waitIdle();
    see("reset seq d", `CIS_OFS_FLAGS, 32'h08, 32'h0);
    see("reset pushes", `CIS_OFS_STATUS, 32'h3000, {18'h0, `CIS_PUSH_WRITES, 12'h0});
    put(`CIS_OFS_FLAGS, 32'h08);
    put(`CIS_OFS_INSTR, mk(`CIS_OP_SWBREAK, 4'h7, 2'h1, 1'b0, 1'b0));
    put(`CIS_OFS_CTRL, 32'h1);
    put(`CIS_OFS_CTRL, 32'h4);
    waitIdle();
    see("break then svc", `CIS_OFS_STATUS, 32'hC0000, 32'hC0000);
    see("svc d", `CIS_OFS_FLAGS, 32'h08, 32'h0);
    $display("test service done");
    summarize();
  end
endmodule
`default_nettype wire
